//--- common/config_pin_pkg.sv
package config_pin_pkg;
  // clock rate and wait timing
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAIT_MIN_US = 30;
  localparam int WAIT_MAX_US = 300;
  // least wait rounds up: 30 us at 40 MHz
  localparam int WAIT_MIN_CYC = (WAIT_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int WAIT_MAX_CYC = (WAIT_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int WAIT_CNT_W = 14;
  // clear pass length in cycles
  localparam int CLEAR_CYC = 64;
  localparam int CLEAR_CNT_W = 7;
  // prom address layout
  localparam int ADDR_W = 18;
  localparam logic [17:0] ADDR_UP_START = 18'h00000;
  localparam logic [17:0] ADDR_DOWN_START = 18'h3FFFF;
  // mode codes, mode pin 2 down to mode pin 0
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;
  localparam logic [2:0] MODE_PAR_UP = 3'h4;
  localparam logic [2:0] MODE_PAR_DOWN = 3'h6;
  localparam logic [2:0] MODE_PERIPH_SYNC = 3'h3;
  localparam logic [2:0] MODE_PERIPH_ASYNC = 3'h5;
  // prom read clock divider: one byte fetch per period
  localparam int RCLK_DIV = 8;
  localparam int RCLK_DIV_W = 3;

  typedef enum logic [2:0] {
    ST_CLEAR, ST_WAIT, ST_SAMPLE, ST_LOAD, ST_ACTIVE
  } cfg_state_e;

  function automatic logic is_master(input logic [2:0] code);
    is_master = (code == MODE_MASTER_SERIAL) || (code == MODE_PAR_UP) ||
                (code == MODE_PAR_DOWN);
  endfunction
endpackage

//--- rtl/config_pin_sequencer.sv
// Contract
// [RL1] read clock rises before each address change
// [RL2] sample mode pins after init rises
// [RL3] mode pins become plain user pins
// [RL4] high_during_config high until I/O active
// [RL5] low_during_config_n low until I/O active
// [RL6] init held low during clear
// [RL7] external init low holds wait state
// [RL8] master modes wait extra 30-300 us
// [RL9] init low flags data error
// [RL10] init released to user after activation
// [RL11] tdo is test out or user output
// [RL12] no scan element: scan pins user
// [RL13] reconfig low clears; then one more clear
// [RL14] done output; held low delays activation
// [RL15] three-bit code selects mode
// [RL16] clear, wait, sample, load, active
`timescale 1ns/1ps
`default_nettype none
module config_pin_sequencer (
  // clock and reset (reset is the reconfiguration request)
  input wire logic clk,
  input wire logic arst_n,
  // mode select pins
  input wire logic [2:0] mode_select_pins_in,
  output logic mode_select_pins_mid_out,
  output logic mode_select_pins_mid_oe,
  // open-drain init line
  input wire logic init_in,
  output logic init_out,
  output logic init_oe,
  // open-drain done line
  input wire logic done_in,
  output logic done_out,
  output logic done_oe,
  // configuration status outputs
  output logic high_during_config,
  output logic low_during_config_n,
  // prom interface
  output logic [config_pin_pkg::ADDR_W-1:0] prom_addr,
  output logic prom_read_clk,
  // loader events
  input wire logic load_complete,
  input wire logic data_error,
  input wire logic done_wait_en,
  // boundary scan
  input wire logic boundary_scan_element,
  input wire logic scan_tdo,
  output logic tdo_out,
  output logic tdo_oe,
  output logic scan_enable,
  // user logic side after activation
  input wire logic user_mid_out,
  input wire logic user_mid_oe,
  input wire logic user_tdo_out,
  input wire logic user_tdo_oe,
  input wire logic user_init_out,
  input wire logic user_init_oe,
  output logic user_io_active,
  output logic [2:0] mode_code,
  output logic fetch_strobe
);
  import config_pin_pkg::*;

  typedef struct packed {
    cfg_state_e state;
    logic second_pass;
    logic [CLEAR_CNT_W-1:0] clr_cnt;
    logic [WAIT_CNT_W-1:0] wait_cnt;
    logic init_low;
    logic [2:0] mode;
    logic err;
    logic cfg_hi;
    logic cfg_lo_n;
    logic done_drv;
    logic active;
    logic mid_out;
    logic mid_oe;
    logic tdo_out;
    logic tdo_oe;
    logic init_o;
    logic init_e;
    logic scan_en;
  } seq_s;

  seq_s st_reg, st_next;
  logic ag_start, ag_run, ag_fetch;
  logic [ADDR_W-1:0] ag_addr;
  logic ag_rclk;

  assign ag_start = (st_reg.state == ST_SAMPLE);
  assign ag_run = (st_reg.state == ST_LOAD) &&
                  (st_reg.mode == MODE_PAR_UP || st_reg.mode == MODE_PAR_DOWN);

  prom_addr_gen u_addr (
    .clk(clk),
    .arst_n(arst_n),
    .start(ag_start),
    .run(ag_run),
    .down(st_reg.mode == MODE_PAR_DOWN),
    .addr(ag_addr),
    .read_clk(ag_rclk),
    .fetch(ag_fetch)
  );

  // sequencer; status only moves on state transitions
  always_comb begin
    st_next = st_reg;
    st_next.mid_oe = 1'b0;
    st_next.tdo_out = scan_tdo;
    st_next.tdo_oe = 1'b0;
    case (st_reg.state)
      ST_CLEAR: begin
        st_next.clr_cnt = st_reg.clr_cnt + 7'h01;
        if (st_reg.clr_cnt == 7'(CLEAR_CYC - 1)) begin
          st_next.clr_cnt = '0;
          // reset release starts the first full pass, one more full pass follows [RL13]
          if (st_reg.second_pass) begin
            st_next.state = ST_WAIT; // [RL16]
            st_next.init_low = 1'b0; // release init [RL13]
          end else begin
            st_next.second_pass = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        // outside party holding init low keeps us here [RL7]
        if (init_in) begin
          st_next.state = ST_SAMPLE; // [RL16]
          st_next.mode = mode_select_pins_in; // [RL2] [RL15]
          st_next.wait_cnt = '0;
        end
      end
      ST_SAMPLE: begin
        // master modes hold off the extra minimum wait [RL8]
        st_next.wait_cnt = st_reg.wait_cnt + 14'h0001;
        if (!init_in) begin
          st_next.state = ST_WAIT; // [RL7]
        end else if (!is_master(st_reg.mode) ||
                     st_reg.wait_cnt >= 14'(WAIT_MIN_CYC - 1)) begin
          st_next.state = ST_LOAD; // [RL8] [RL16]
        end
      end
      ST_LOAD: begin
        if (data_error) begin
          st_next.err = 1'b1;
          st_next.init_low = 1'b1; // [RL9]
        end else if (load_complete && !st_reg.err) begin
          st_next.done_drv = 1'b0; // release done [RL14]
        end
        // done stays released, so a pulse is enough to wait on done_in
        if (!st_reg.err && !data_error &&
            (load_complete || !st_reg.done_drv) &&
            (!done_wait_en || done_in)) begin
          st_next.state = ST_ACTIVE; // [RL14] [RL16]
          st_next.active = 1'b1;
          st_next.cfg_hi = 1'b0; // [RL4]
          st_next.cfg_lo_n = 1'b1; // [RL5]
          st_next.scan_en = boundary_scan_element; // [RL12]
        end
      end
      ST_ACTIVE: begin
        // pins hand over to user logic, registered one cycle behind user terms [RL3]
        st_next.mid_out = user_mid_out; // [RL3]
        st_next.mid_oe = user_mid_oe; // [RL3]
        st_next.init_o = user_init_out; // [RL10]
        st_next.init_e = user_init_oe; // [RL10]
        if (!st_reg.scan_en) begin
          st_next.tdo_out = user_tdo_out; // [RL11]
          st_next.tdo_oe = user_tdo_oe; // [RL11]
        end else begin
          st_next.tdo_oe = 1'b1; // [RL11]
        end
      end
      default: begin
        st_next.state = ST_CLEAR;
      end
    endcase
    if (st_reg.state != ST_ACTIVE) begin
      // configuration role: open-drain drive low only [RL6] [RL9]
      st_next.init_o = 1'b0;
      st_next.init_e = st_next.init_low;
    end
  end

  // reset is the reconfiguration request: clear with init low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.state <= ST_CLEAR;
      st_reg.init_low <= 1'b1; // [RL6]
      st_reg.init_e <= 1'b1; // [RL6]
      st_reg.cfg_hi <= 1'b1; // [RL4]
      st_reg.cfg_lo_n <= 1'b0; // [RL5]
      st_reg.done_drv <= 1'b1; // [RL14]
      st_reg.scan_en <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mode_select_pins_mid_out = st_reg.mid_out;
  assign mode_select_pins_mid_oe = st_reg.mid_oe;
  assign init_out = st_reg.init_o;
  assign init_oe = st_reg.init_e;
  // done is open-drain: low until configured, then released
  assign done_out = 1'b0;
  assign done_oe = st_reg.done_drv;
  assign high_during_config = st_reg.cfg_hi;
  assign low_during_config_n = st_reg.cfg_lo_n;
  assign prom_addr = ag_addr;
  assign prom_read_clk = ag_rclk;
  assign tdo_out = st_reg.tdo_out;
  assign tdo_oe = st_reg.tdo_oe;
  assign scan_enable = st_reg.scan_en;
  assign user_io_active = st_reg.active;
  assign mode_code = st_reg.mode;
  assign fetch_strobe = ag_fetch;
endmodule // config_pin_sequencer
`default_nettype wire

//--- rtl/prom_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
module prom_addr_gen (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic start,
  input wire logic run,
  input wire logic down,
  // prom side
  output logic [config_pin_pkg::ADDR_W-1:0] addr,
  output logic read_clk,
  output logic fetch
);
  import config_pin_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [RCLK_DIV_W-1:0] div;
    logic read_clk;
    logic fetch;
  } ag_s;

  ag_s st_reg, st_next;

  // read clock rises at div==0, address moves half a period later
  always_comb begin
    st_next = st_reg;
    st_next.fetch = 1'b0;
    if (start) begin
      st_next.addr = down ? ADDR_DOWN_START : ADDR_UP_START;
      st_next.div = '0;
      st_next.read_clk = 1'b0;
    end else if (run) begin
      st_next.div = st_reg.div + 3'h1;
      if (st_reg.div == 3'h0) begin
        st_next.read_clk = 1'b1; // [RL1]
        st_next.fetch = 1'b1;
      end
      if (st_reg.div == 3'(RCLK_DIV / 2)) begin
        st_next.read_clk = 1'b0;
        // change only after the rising edge above [RL1]
        st_next.addr = down ? st_reg.addr - 18'h00001
                            : st_reg.addr + 18'h00001;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign addr = st_reg.addr;
  assign read_clk = st_reg.read_clk;
  assign fetch = st_reg.fetch;
endmodule // prom_addr_gen
`default_nettype wire

//--- testbench/config_pin_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
module config_pin_sequencer_props (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // open-drain lines
  input wire logic init_out,
  input wire logic init_oe,
  input wire logic done_out,
  input wire logic done_oe,
  // status and prom
  input wire logic high_during_config,
  input wire logic low_during_config_n,
  input wire logic prom_read_clk,
  input wire logic fetch_strobe,
  // user side
  input wire logic mode_select_pins_mid_out,
  input wire logic mode_select_pins_mid_oe,
  input wire logic user_mid_out,
  input wire logic user_mid_oe,
  input wire logic user_init_out,
  input wire logic user_init_oe,
  input wire logic user_tdo_out,
  input wire logic user_tdo_oe,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic scan_tdo,
  input wire logic scan_enable,
  input wire logic boundary_scan_element,
  input wire logic user_io_active,
  // done handshake
  input wire logic done_in,
  input wire logic done_wait_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // copies lag one cycle, so look only once user mode has settled
  sequence s_user;
    user_io_active && $past(user_io_active);
  endsequence
  // settled user mode with the scan element kept or left out
  sequence s_scan;
    s_user ##0 $past(boundary_scan_element);
  endsequence
  sequence s_noscan;
    s_user ##0 !$past(boundary_scan_element);
  endsequence
  chk_high_user: assert property (
    high_during_config == !user_io_active)
    else $error("high_during_config mismatch");
  chk_low_user: assert property (
    low_during_config_n == user_io_active)
    else $error("low_during_config_n mismatch");
  chk_init_drive: assert property (
    init_oe && !user_io_active |-> !init_out)
    else $error("init driven high");
  // with done waiting off, release and hand-over share one edge
  chk_done_hold: assert property (
    !user_io_active && !done_wait_en |-> done_oe && !done_out)
    else $error("done released early");
  chk_done_free: assert property (
    user_io_active |-> !done_oe)
    else $error("done still driven in user mode");
  chk_done_delay: assert property (
    $rose(user_io_active) |-> !$past(done_wait_en) || $past(done_in))
    else $error("hand-over while done held low");
  chk_rclk_rise: assert property (
    fetch_strobe |-> prom_read_clk && !$past(prom_read_clk))
    else $error("fetch without read clock rise");
  chk_mid_quiet: assert property (
    !user_io_active |-> !mode_select_pins_mid_oe)
    else $error("middle mode pin driven in config");
  chk_mid_pass: assert property (
    s_user |-> mode_select_pins_mid_out == $past(user_mid_out) &&
    mode_select_pins_mid_oe == $past(user_mid_oe))
    else $error("middle mode pin not passed");
  chk_scan_cfg: assert property (
    !user_io_active |-> scan_enable)
    else $error("scan off in config");
  chk_scan_user: assert property (
    s_user |-> scan_enable == $past(boundary_scan_element))
    else $error("scan enable wrong");
  chk_tdo_user: assert property (
    s_noscan |-> tdo_out == $past(user_tdo_out) &&
    tdo_oe == $past(user_tdo_oe))
    else $error("tdo not user");
  chk_tdo_scan: assert property (
    s_scan |-> tdo_oe && tdo_out == $past(scan_tdo))
    else $error("tdo not test data");
  chk_init_user: assert property (
    s_user |-> init_oe == $past(user_init_oe) &&
    init_out == $past(user_init_out))
    else $error("init not user");
endmodule // config_pin_sequencer_props
bind config_pin_sequencer config_pin_sequencer_props chk_u (.*);
`default_nettype wire

//--- testbench/config_pin_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module config_pin_sequencer_tb;
  import config_pin_pkg::*;
  logic clk = 0, arst_n = 0, hold = 1, init_in, done_in;
  logic [2:0] mode = 3'h0;
  logic lc = 0, de = 0, bse = 0, umid = 0, utdo = 0, uioe = 0;
  logic dwe = 0, hold_done = 0;
  logic init_out, init_oe, done_out, done_oe, cfg_hi, cfg_lo_n, fs, act;
  logic [17:0] addr;
  logic [2:0] code;
  logic scan_en;
  int fails = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  config_supervisor sup_u (.init_out(init_out), .init_oe(init_oe),
    .done_out(done_out), .done_oe(done_oe), .hold_init(hold),
    .hold_done(hold_done), .init_in(init_in), .done_in(done_in));
  config_pin_sequencer dut_u (.clk(clk), .arst_n(arst_n),
    .mode_select_pins_in(mode), .mode_select_pins_mid_out(),
    .mode_select_pins_mid_oe(), .init_in(init_in), .init_out(init_out),
    .init_oe(init_oe), .done_in(done_in), .done_out(done_out),
    .done_oe(done_oe), .high_during_config(cfg_hi),
    .low_during_config_n(cfg_lo_n), .prom_addr(addr), .prom_read_clk(),
    .load_complete(lc), .data_error(de), .done_wait_en(dwe),
    .boundary_scan_element(bse), .scan_tdo(~utdo), .tdo_out(), .tdo_oe(),
    .scan_enable(scan_en), .user_mid_out(umid), .user_mid_oe(umid),
    .user_tdo_out(utdo), .user_tdo_oe(uioe), .user_init_out(utdo),
    .user_init_oe(uioe), .user_io_active(act), .mode_code(code),
    .fetch_strobe(fs));
  task automatic cmp(string what, logic [17:0] exp, logic [17:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task print_verdict;
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reset, then two clear passes with init pulled low
  task automatic t_reset_clear;
    arst_n = 0;
    repeat (12) @(negedge clk);
    arst_n = 1;
    repeat (127) @(negedge clk);
    cmp("init_oe clear", 1, init_oe);
    cmp("high_during_config", 1, cfg_hi);
    cmp("low_during_config_n", 0, cfg_lo_n);
    repeat (4) @(negedge clk);
    cmp("init_oe wait", 0, init_oe);
  endtask
  // one mode: held in wait, timed start, load, hand-over
  task automatic t_mode(input logic [2:0] m);
    int first;
    logic [17:0] a;
    logic [17:0] a2;
    logic par;
    first = -1;
    par = (m == MODE_PAR_UP) || (m == MODE_PAR_DOWN);
    mode = m;
    bse = m[0];
    umid = m[1];
    uioe = m[2];
    utdo = ~m[0];
    hold = 1;
    t_reset_clear();
    repeat (60) @(negedge clk);
    cmp("no fetch held", 0, fs);
    hold = 0;
    for (int n = 0; n < 1300; n++) begin
      @(negedge clk);
      if (fs === 1'b1 && first < 0) begin
        first = n;
        a = addr;
      end
      // one read clock period later the address has stepped once
      if (first >= 0 && n == first + 8) a2 = addr;
    end
    if (par) begin
      cmp("master wait", 1, first >= 1199);
      cmp("start addr", (m == MODE_PAR_UP) ? ADDR_UP_START
          : ADDR_DOWN_START, a);
      cmp("step addr", (m == MODE_PAR_UP) ? 18'h00001 : 18'h3FFFE, a2);
    end
    lc = 1;
    @(negedge clk);
    lc = 0;
    repeat (2) @(negedge clk);
    cmp("active", 1, act);
    cmp("high_during_config user", 0, cfg_hi);
    cmp("low_during_config_n user", 1, cfg_lo_n);
    cmp("mode_code", m, code);
    cmp("scan_en", bse, scan_en);
  endtask
  // data error reported on init; later completion ignored
  task automatic t_data_error;
    mode = MODE_SLAVE_SERIAL;
    hold = 0;
    t_reset_clear();
    repeat (20) @(negedge clk);
    de = 1;
    @(negedge clk);
    de = 0;
    repeat (3) @(negedge clk);
    cmp("init error", 0, init_in);
    lc = 1;
    @(negedge clk);
    lc = 0;
    repeat (3) @(negedge clk);
    cmp("active after error", 0, act);
    cmp("init held", 0, init_in);
  endtask
  // init pulled low mid-wait restarts it; held done delays hand-over
  task automatic t_done_wait;
    int n;
    mode = MODE_PAR_UP;
    hold = 0;
    dwe = 1;
    hold_done = 1;
    t_reset_clear();
    repeat (100) @(negedge clk);
    hold = 1;
    repeat (4) @(negedge clk);
    hold = 0;
    n = 0;
    while (fs !== 1'b1 && n < 1300) begin
      @(negedge clk);
      n++;
    end
    cmp("rewait", 1, n >= 1200 && fs === 1'b1);
    lc = 1;
    @(negedge clk);
    lc = 0;
    repeat (5) @(negedge clk);
    cmp("done released", 0, done_oe);
    cmp("held by done", 0, act);
    hold_done = 0;
    repeat (2) @(negedge clk);
    cmp("active after done", 1, act);
  endtask
  // main sequence: every mode code, the error case, then done wait
  initial begin
    for (int i = 0; i < 8; i++) t_mode(i[2:0]);
    t_data_error();
    t_done_wait();
    print_verdict();
  end
  // expected run is about 14000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule // config_pin_sequencer_tb
`default_nettype wire

//--- testbench/config_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module config_supervisor (
  // device drives
  input wire logic init_out,
  input wire logic init_oe,
  input wire logic done_out,
  input wire logic done_oe,
  // board supervisor holds init low
  input wire logic hold_init,
  // board supervisor holds done low
  input wire logic hold_done,
  // wire levels
  output logic init_in,
  output logic done_in
);
  // both lines have pull-ups, so released means high
  assign init_in = !((init_oe && !init_out) || hold_init);
  assign done_in = !((done_oe && !done_out) || hold_done);
endmodule // config_supervisor
`default_nettype wire
